/* File: core/ebi_pkg.sv */
// Package of constants and types for the external bus interface
package ebi_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int AREA_N = 4;
	localparam int FIFO_DEPTH = 8;
	// Request word: write flag, address, data
	localparam int REQ_W = 1 + ADDR_W + DATA_W;
	localparam int REQ_WR_POS = REQ_W - 1;
	localparam int REQ_ADDR_LSB = DATA_W;
	// Area decode uses the two top address bits
	localparam int AREA_LSB = ADDR_W - 2;
	// Timing
	localparam int CLK_MHZ = 50;
	localparam int ALE_NS = 20;
	localparam int ALE_CYC = (ALE_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_NS = 40;
	localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 4;
	// Register map
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_RDATA = 4'h8;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int CTRL_MUX_POS = 0;
	localparam int CTRL_ALT_POS = 1;
	localparam int CTRL_EN_POS = 2;
	typedef enum logic [2:0] {
		EBI_IDLE = 3'b000,
		EBI_ADDR = 3'b001,
		EBI_STRB = 3'b010,
		EBI_WAIT = 3'b011,
		EBI_DONE = 3'b100
	} ebi_state_e;
endpackage

/* File: core/ebi_fifo.sv */
// Request FIFO with parameterised width and depth
module ebi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wr_ptr_reg;
	logic [PW:0] rd_ptr_reg;
	wire full = (wr_ptr_reg[PW] != rd_ptr_reg[PW]) && (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);
	wire empty = wr_ptr_reg == rd_ptr_reg;
	wire push = in_valid_i && !full;
	wire pop = out_ready_i && !empty;
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem[rd_ptr_reg[PW-1:0]];
	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr_reg[PW-1:0]] <= in_data_i;
		end
	end
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule

/* File: core/ebi_core.sv */
// External bus interface: bus cycle sequencer and control registers
// ****************************************************************
// What this block does
// RL1: Width select low gives 16-bit data bus, high gives 8-bit bus.
// RL2: Processor-mode pin low starts single-chip; high starts external bus mode.
// RL3: Separate bus carries the low data byte on lines 0 to 7.
// RL4: Upper data lines 8 to 15 used only on 16-bit separate bus.
// RL5: Drive twenty address outputs, bits 0 to 19.
// RL6: 8-bit multiplexed: shared lines carry address 0-7, then data 0-7.
// RL7: 16-bit multiplexed: shared lines carry address 1-8, then data 0-7.
// RL8: Four active-low area selects; the accessed area's select goes low.
// RL9: 16-bit split-strobe write to even address drives low-byte strobe low.
// RL10: Split-strobe write to odd address drives high-byte strobe low; on an 8-bit bus here it drives the low-byte strobe instead.
// RL11: Read data while the active-low read strobe is held low.
// RL12: Alternate scheme: single write strobe plus byte-high enable for odd accesses.
// RL13: Software selects the alternate strobe scheme with an 8-bit bus.
// RL14: Drive address latch enable so external logic can capture the address.
// RL15: Hold request unsupported; its input stays pulled high externally.
// RL16: Hold acknowledge goes low whenever in a bus hold state.
// RL17: Insert wait states while the ready input is held low.
// RL18: Latch enable high in address phase, low before shared lines turn data; here it falls on the same edge.
// ****************************************************************
//
// Implementation choices: strobed register access and the placing of the registers.
module ebi_core #(
	parameter int FIFO_D = ebi_pkg::FIFO_DEPTH
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic req_write_i,
	input wire logic [ebi_pkg::ADDR_W-1:0] req_addr_i,
	input wire logic [ebi_pkg::DATA_W-1:0] req_wdata_i,
	output logic rsp_valid_o,
	output logic [ebi_pkg::DATA_W-1:0] rsp_rdata_o,
	input wire logic byte_mode_i,
	input wire logic processor_mode_pin_i,
	output logic [ebi_pkg::ADDR_W-1:0] addr_o,
	input wire logic [ebi_pkg::DATA_W-1:0] data_i,
	output logic [ebi_pkg::DATA_W-1:0] data_o,
	output logic [ebi_pkg::DATA_W-1:0] data_oe_o,
	output logic [ebi_pkg::AREA_N-1:0] area_select_n_o,
	output logic low_byte_write_strobe_n_o,
	output logic high_byte_write_strobe_n_o,
	output logic read_strobe_n_o,
	output logic addr_latch_en_o,
	input wire logic hold_req_n_i,
	output logic hold_acknowledge_n_o,
	input wire logic ready_n_i,
	output logic ext_mode_o
);
	import ebi_pkg::*;
	// ****************************************************************
	// Control register and mode strap
	// ****************************************************************
	logic [7:0] ctrl_reg;
	logic strap_done_reg;
	logic ext_mode_reg;
	logic [15:0] rdata_reg;
	logic [DATA_W-1:0] last_rd_reg;
	wire ctrl_mux = ctrl_reg[CTRL_MUX_POS];
	// With an 8-bit bus, software is expected to pick the alternate scheme
	wire ctrl_alt = ctrl_reg[CTRL_ALT_POS]; // [RL13]
	wire ctrl_en = ctrl_reg[CTRL_EN_POS];
	wire sel_ctrl = reg_addr_i == REG_CTRL;
	wire sel_stat = reg_addr_i == REG_STAT;
	wire sel_rdat = reg_addr_i == REG_RDATA;
	ebi_state_e state_reg;
	ebi_state_e state_next;
	wire busy = state_reg != EBI_IDLE;
	wire [15:0] stat_word = {11'h000, byte_mode_i, ready_n_i, ext_mode_reg, busy, ctrl_en};
	wire [15:0] rd_mux = sel_ctrl ? {8'h00, ctrl_reg} :
		sel_stat ? stat_word :
		sel_rdat ? last_rd_reg : 16'h0000;
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_reg <= CTRL_RESET;
			rdata_reg <= 16'h0000;
		end else begin
			if (reg_wr_i && sel_ctrl) ctrl_reg <= reg_wdata_i;
			rdata_reg <= reg_rd_i ? rd_mux : 16'h0000;
		end
	end
	assign reg_rdata_o = rdata_reg;
	// Mode pin caught on the first edge after reset release, not by the reset
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			strap_done_reg <= 1'b0;
			ext_mode_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'b1;
			ext_mode_reg <= processor_mode_pin_i; // [RL2]
		end
	end
	assign ext_mode_o = ext_mode_reg;
	// ****************************************************************
	// Request FIFO
	// ****************************************************************
	logic fifo_valid;
	logic [REQ_W-1:0] fifo_data;
	wire take = (state_reg == EBI_IDLE) && fifo_valid && ext_mode_reg && ctrl_en;
	ebi_fifo #(
		.WIDTH(REQ_W),
		.DEPTH(FIFO_D)
	) u_fifo (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(req_valid_i),
		.in_ready_o(req_ready_o),
		.in_data_i({req_write_i, req_addr_i, req_wdata_i}),
		.out_valid_o(fifo_valid),
		.out_ready_i(take),
		.out_data_o(fifo_data)
	);
	// ****************************************************************
	// Bus cycle sequencer
	// ****************************************************************
	logic [CNT_W-1:0] cnt_reg;
	logic wr_reg;
	logic [ADDR_W-1:0] a_reg;
	logic [DATA_W-1:0] d_reg;
	wire [DATA_W-1:0] bus_rd;
	wire odd = a_reg[0];
	wire [1:0] area = a_reg[AREA_LSB +: 2];
	wire cnt_zero = cnt_reg == '0;
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			EBI_IDLE: begin
				if (take) state_next = ctrl_mux ? EBI_ADDR : EBI_STRB;
			end
			EBI_ADDR: begin
				if (cnt_zero) state_next = EBI_STRB;
			end
			EBI_STRB: begin
				if (cnt_zero) state_next = EBI_WAIT;
			end
			EBI_WAIT: begin
				if (!ready_n_i) state_next = EBI_WAIT; // [RL17]
				else state_next = EBI_DONE;
			end
			EBI_DONE: begin
				state_next = EBI_IDLE;
			end
			default: begin
				state_next = EBI_IDLE;
			end
		endcase
	end
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= EBI_IDLE;
			cnt_reg <= '0;
			wr_reg <= 1'b0;
			a_reg <= '0;
			d_reg <= '0;
			last_rd_reg <= '0;
			rsp_valid_o <= 1'b0;
			rsp_rdata_o <= '0;
		end else begin
			state_reg <= state_next;
			rsp_valid_o <= 1'b0;
			if (take) begin
				wr_reg <= fifo_data[REQ_WR_POS];
				a_reg <= fifo_data[REQ_ADDR_LSB +: ADDR_W];
				d_reg <= fifo_data[DATA_W-1:0];
				cnt_reg <= ctrl_mux ? CNT_W'(ALE_CYC - 1) : CNT_W'(STROBE_CYC - 1);
			end else if (state_reg == EBI_ADDR && cnt_zero) begin
				cnt_reg <= CNT_W'(STROBE_CYC - 1);
			end else if (!cnt_zero) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
			// Sample at the end of the strobe, once ready has released
			if (state_reg == EBI_WAIT && ready_n_i) begin
				rsp_valid_o <= 1'b1;
				rsp_rdata_o <= wr_reg ? '0 : bus_rd;
				if (!wr_reg) last_rd_reg <= bus_rd; // [RL11]
			end
		end
	end
	// ****************************************************************
	// Pin drive
	// ****************************************************************
	wire active = state_reg == EBI_STRB || state_reg == EBI_WAIT;
	wire in_cycle = busy && state_reg != EBI_DONE;
	wire addr_ph = state_reg == EBI_ADDR;
	wire wide = !byte_mode_i; // [RL1]
	// Multiplexed address rides lines 0-7; 16-bit mode shifts by one
	wire [7:0] mux_addr = wide ? a_reg[8:1] : a_reg[7:0]; // [RL6] [RL7]
	wire [7:0] lo_byte = (!wide || !odd) ? d_reg[7:0] : d_reg[15:8];
	assign bus_rd = (wide && !ctrl_mux) ? data_i : {8'h00, data_i[7:0]}; // [RL3]
	always_comb begin
		data_o = '0;
		data_oe_o = '0;
		if (addr_ph) begin
			data_o[7:0] = mux_addr;
			data_oe_o[7:0] = 8'hFF;
		end else if (active && wr_reg) begin
			data_o[7:0] = (wide && !ctrl_mux) ? d_reg[7:0] : lo_byte; // [RL3]
			data_oe_o[7:0] = 8'hFF;
			if (wide && !ctrl_mux) begin
				data_o[15:8] = d_reg[15:8]; // [RL4]
				data_oe_o[15:8] = 8'hFF;
			end
		end
	end
	assign addr_o = in_cycle ? a_reg : '0; // [RL5]
	assign area_select_n_o = in_cycle ? ~(AREA_N'(1) << area) : '1; // [RL8]
	// Latch enable falls on the same edge that switches the shared lines to data
	assign addr_latch_en_o = addr_ph; // [RL14] [RL18]
	wire wstb = active && wr_reg;
	// Split scheme: even to low strobe, odd to high strobe on a 16-bit bus, to low strobe on an 8-bit bus
	// Alternate: low pin is the single write strobe, high pin is byte-high enable
	assign low_byte_write_strobe_n_o = ctrl_alt ? !wstb : !(wstb && (!odd || !wide)); // [RL9] [RL12]
	assign high_byte_write_strobe_n_o = ctrl_alt ? !(in_cycle && odd) : !(wstb && odd && wide); // [RL10] [RL12]
	assign read_strobe_n_o = !(active && !wr_reg); // [RL11]
	// Hold request is not served, so the bus never enters hold
	assign hold_acknowledge_n_o = 1'b1; // [RL15] [RL16]
endmodule

/* File: verif/ebi_mem_model.sv */
// Behavioural external memory on the parallel bus
module ebi_mem_model (
	input wire logic clock_i,
	input wire logic byte_mode_i,
	input wire logic [3:0] wait_i,
	input wire logic [19:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic rd_n_i,
	input wire logic wrl_n_i,
	input wire logic wrh_n_i,
	input wire logic ale_i,
	output logic [15:0] rdata_o,
	output logic ready_n_o
);
	// ****
	// Storage and wait generation
	// ****
	logic [7:0] mem [32];
	logic [15:0] last;
	logic [3:0] cnt;
	wire [4:0] a = addr_i[4:0];
	// Address phase never counts as an access, whatever the byte-high pin shows
	wire sel = !ale_i && (!rd_n_i || !wrl_n_i || !wrh_n_i);
	wire [15:0] rd_val = byte_mode_i ? {8'h00, mem[a]} : {mem[a | 5'h01], mem[a & 5'h1E]};
	// Slow device: ready held low for wait_i cycles of each strobe
	assign ready_n_o = !(sel && (cnt < wait_i));
	// Released lines show the inverse so a stale value never passes
	assign rdata_o = rd_n_i ? ~last : rd_val;
	initial last = 16'h0000;
	always @(posedge clock_i) begin
		cnt <= sel ? cnt + 4'h1 : 4'h0;
		if (!rd_n_i)
			last <= rd_val;
		// Byte-high enable also falls on odd reads, so writes need read high
		if (sel && rd_n_i)
			mem[a] <= (a[0] && !byte_mode_i) ? wdata_i[15:8] : wdata_i[7:0];
	end
endmodule

/* File: verif/ebi_core_asserts.sv */
// Checker of the external bus pin behaviour
module ebi_core_asserts (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic rsp_valid_o,
	input wire logic byte_mode_i,
	input wire logic [ebi_pkg::ADDR_W-1:0] addr_o,
	input wire logic [ebi_pkg::DATA_W-1:0] data_o,
	input wire logic [ebi_pkg::DATA_W-1:0] data_oe_o,
	input wire logic [ebi_pkg::AREA_N-1:0] area_select_n_o,
	input wire logic low_byte_write_strobe_n_o,
	input wire logic high_byte_write_strobe_n_o,
	input wire logic read_strobe_n_o,
	input wire logic addr_latch_en_o,
	input wire logic hold_acknowledge_n_o,
	input wire logic ready_n_i,
	input wire logic ext_mode_o
);
	import ebi_pkg::*;
	// ****
	// Pin relations
	// ****
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	wire strb = !read_strobe_n_o || !low_byte_write_strobe_n_o;
	chk_hold_ack_high: assert property (hold_acknowledge_n_o)
		else $error("hold ack low");
	chk_area_match: assert property (strb |-> area_select_n_o == ~(4'h1 << addr_o[AREA_LSB +: 2]))
		else $error("wrong area select");
	chk_upper_quiet: assert property (byte_mode_i |-> data_oe_o[15:8] == 8'h00)
		else $error("upper lines driven");
	chk_read_len: assert property ($fell(read_strobe_n_o) |-> !read_strobe_n_o [*2])
		else $error("read strobe short");
	chk_wait_stretch: assert property (!ready_n_i && strb |=> !rsp_valid_o)
		else $error("cycle ended in wait");
	chk_even_low: assert property (!low_byte_write_strobe_n_o && !byte_mode_i && !addr_o[0]
		|-> high_byte_write_strobe_n_o)
		else $error("high strobe on even");
	chk_odd_high: assert property (!high_byte_write_strobe_n_o |-> addr_o[0])
		else $error("high strobe on even address");
	chk_ale_phase: assert property (addr_latch_en_o |-> !strb ##1 !addr_latch_en_o)
		else $error("latch enable overlap");
	chk_mux_addr: assert property (addr_latch_en_o |-> data_oe_o[7:0] == 8'hFF
		&& data_o[7:0] == (byte_mode_i ? addr_o[7:0] : addr_o[8:1]))
		else $error("wrong shared address");
	chk_low_lane: assert property (!low_byte_write_strobe_n_o && !addr_o[0]
		|-> data_oe_o[7:0] == 8'hFF)
		else $error("low lane undriven");
	chk_mode_gate: assert property (!ext_mode_o |-> area_select_n_o == 4'hF)
		else $error("select in single-chip");
	cover property (rsp_valid_o);
	cover property (addr_latch_en_o);
	cover property (!ready_n_i && strb);
endmodule
bind ebi_core ebi_core_asserts i_chk (.*);

/* File: verif/ebi_core_test.sv */
// Testbench of the external bus interface core
module ebi_core_test;
	timeunit 1ns;
	timeprecision 1ns;
	import ebi_pkg::*;
	logic clock_i, rst_b_i, reg_wr_i, reg_rd_i, req_valid_i, req_write_i, byte_mode_i;
	logic processor_mode_pin_i, hold_req_n_i, ready_n_i, req_ready_o, rsp_valid_o;
	logic low_byte_write_strobe_n_o, high_byte_write_strobe_n_o, read_strobe_n_o;
	logic addr_latch_en_o, hold_acknowledge_n_o, ext_mode_o;
	logic [3:0] reg_addr_i, area_select_n_o, wt;
	logic [7:0] reg_wdata_i;
	logic [15:0] reg_rdata_o, req_wdata_i, rsp_rdata_o, data_i, data_o, data_oe_o;
	logic [19:0] req_addr_i, addr_o;
	int fail_count, checks_done;
	ebi_core i_dut (.*);
	ebi_mem_model i_mem (.clock_i(clock_i), .byte_mode_i(byte_mode_i), .wait_i(wt),
		.addr_i(addr_o), .wdata_i(data_o), .rd_n_i(read_strobe_n_o),
		.wrl_n_i(low_byte_write_strobe_n_o), .wrh_n_i(high_byte_write_strobe_n_o),
		.ale_i(addr_latch_en_o),
		.rdata_o(data_i), .ready_n_o(ready_n_i));
	always #10 clock_i = ~clock_i;
	// ****
	// Access tasks
	// ****
	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask
	task automatic do_reset(input logic pin, input logic bm);
		rst_b_i <= 1'b0;
		processor_mode_pin_i <= pin;
		byte_mode_i <= bm;
		repeat (10) @(posedge clock_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clock_i);
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1 cmp(reg_rdata_o, e, "register read");
	endtask
	// Bus request; m masks the byte lane that the access carries
	task automatic bus(input logic w, input logic [19:0] a, input logic [15:0] d,
		input logic [15:0] m, input logic [15:0] e);
		int n;
		@(posedge clock_i);
		req_valid_i <= 1'b1;
		req_write_i <= w;
		req_addr_i <= a;
		req_wdata_i <= d;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (req_ready_o !== 1'b1 && n < 20);
		req_valid_i <= 1'b0;
		// A request the FIFO never accepts (req_ready_o low) skips the wait and fails below
		n = (req_ready_o === 1'b1) ? 0 : 60;
		while (n < 60 && rsp_valid_o !== 1'b1) begin
			@(posedge clock_i);
			#1 n++;
		end
		if (rsp_valid_o !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED t=%0t no response", $time);
			end_sim;
		end else begin
			cmp(rsp_rdata_o & m, e, "bus data");
		end
	endtask
	// ****
	// Sequence
	// ****
	initial begin
		clock_i = 1'b0;
		{reg_wr_i, reg_rd_i, req_valid_i, req_write_i} = 4'h0;
		hold_req_n_i = 1'b1;
		reg_addr_i = 4'h0;
		reg_wdata_i = 8'h00;
		req_addr_i = 20'h00000;
		req_wdata_i = 16'h0000;
		wt = 4'h0;
		do_reset(1'b0, 1'b0);
		#1 cmp({15'h0000, ext_mode_o}, 16'h0000, "single-chip");
		reg_rd(REG_CTRL, {8'h00, CTRL_RESET});
		$display("Test single-chip done");
		do_reset(1'b1, 1'b0);
		#1 cmp({15'h0000, ext_mode_o}, 16'h0001, "external mode");
		reg_rd(REG_STAT, 16'h000C);
		reg_rd(4'hC, 16'h0000);
		reg_wr(REG_CTRL, 8'h04);
		wt = 4'h3;
		bus(1'b1, 20'hC0002, 16'h0034, 16'hFFFF, 16'h0000);
		bus(1'b1, 20'hC0003, 16'hAB00, 16'hFFFF, 16'h0000);
		bus(1'b0, 20'hC0002, 16'h0000, 16'h00FF, 16'h0034);
		bus(1'b0, 20'hC0003, 16'h0000, 16'hFF00, 16'hAB00);
		wt = 4'h0;
		reg_wr(REG_CTRL, 8'h05);
		bus(1'b1, 20'h40014, 16'h0055, 16'hFFFF, 16'h0000);
		bus(1'b0, 20'h40014, 16'h0000, 16'h00FF, 16'h0055);
		$display("Test word bus done");
		do_reset(1'b1, 1'b1);
		reg_wr(REG_CTRL, 8'h06);
		bus(1'b1, 20'h80005, 16'h005A, 16'hFFFF, 16'h0000);
		bus(1'b0, 20'h80005, 16'h0000, 16'h00FF, 16'h005A);
		reg_wr(REG_CTRL, 8'h07);
		bus(1'b1, 20'h00011, 16'h0066, 16'hFFFF, 16'h0000);
		bus(1'b0, 20'h00011, 16'h0000, 16'h00FF, 16'h0066);
		$display("Test byte bus done");
		end_sim;
	end
endmodule
